/* phantom_rtc_map.svh */
// named offsets, key and counts of the phantom clock access sequencer
// assumes inclusion by every file that needs the constants
`ifndef PHANTOM_RTC_MAP_SVH
`define PHANTOM_RTC_MAP_SVH

// key, sent lsb first: c5 3a a3 5c c5 3a a3 5c
`define PR_KEY          64'h5CA3_3AC5_5CA3_3AC5
// first and last bit index of key and of transfer
`define PR_IDX_FIRST    6'h00
`define PR_IDX_LAST     6'h3F
// last bit inside one 8-bit clock register
`define PR_BYTE_LAST    3'h7
// reset-enable bit: bit 4 of day register 4
`define PR_RST_EN_BIT   6'h24
// two-entry buffer depth
`define PR_BUF_DEPTH    2

`endif

/* phantom_rtc_pkg.sv */
// types shared by the phantom clock access sequencer files
// assumes phantom_rtc_map.svh holds the numbers
package phantom_rtc_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,   // pass-through, pointer not armed
        SEQ_MATCH,  // comparing written bits against key
        SEQ_FAIL,   // mismatch seen, writes ignored
        SEQ_XFER    // 64 clock data cycles
    } seq_state_e;

    typedef logic [5:0] bit_idx_t;  // key pointer / transfer count
    typedef logic [2:0] reg_idx_t;  // clock register number
    typedef logic [7:0] byte_t;     // one clock register

endpackage : phantom_rtc_pkg

/* phantom_rtc_buf.sv */
// two-entry buffer with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`include "phantom_rtc_map.svh"

module phantom_rtc_buf #(
    parameter int WIDTH = 11,
    parameter int DEPTH = `PR_BUF_DEPTH
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_arst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];   // storage
    logic [AW-1:0]    wr_q;            // write slot
    logic [AW-1:0]    rd_q;            // read slot
    logic [AW:0]      cnt_q;           // fill level
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_q[rd_q];

    // ---------------------------------------------------------------
    // storage and pointers
    // ---------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            if (push) begin
                mem_q[wr_q] <= i_in_data;
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : phantom_rtc_buf

/* phantom_rtc_access_sequencer.sv */
// access sequencer of a phantom clock in series with a memory select
// assumes bus pins already synchronous to i_sys_clk; counters outside
//
// How it works
// - unlock only after 64 matching key writes
// - before unlock, pass select to memory
// - during transfer, hold memory select high
// - a read arms pointer at key bit 0
// - matching write bit advances the pointer
// - mismatch freezes pointer, later writes ignored
// - read during matching restarts the attempt
// - key writes never reach clock registers
// - each transfer cycle moves one bit
// - cycles elsewhere leave progress untouched
// - power fail forces memory select high
// - normal supply, no transfer: memory select follows input
// - power fail aborts and refuses access
// - key c5 3a a3 5c twice, lsb first
// - transfer walks register 0 bit 0 onward
// - reset pin aborts unless reset bit set
`timescale 1ns/1ps
`include "phantom_rtc_map.svh"

module phantom_rtc_access_sequencer (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_arst_n,
    input  wire logic                   i_chip_sel_in_n,
    input  wire logic                   i_oe_n,
    input  wire logic                   i_we_n,
    input  wire logic                   i_data_in,
    input  wire logic                   i_below_threshold,
    input  wire logic                   i_abort_pin_n,
    input  wire logic [63:0]            i_clock_image,
    input  wire logic                   i_tk_ready,
    output logic                        o_memory_sel_out_n,
    output logic                        o_data_out,
    output logic                        o_data_out_oe,
    output logic                        o_xfer_active,
    output logic                        o_tk_valid,
    output phantom_rtc_pkg::reg_idx_t   o_tk_index,
    output phantom_rtc_pkg::byte_t      o_tk_data
);
    import phantom_rtc_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // key bit under the pointer
    function automatic logic key_bit(input bit_idx_t idx);
        logic [63:0] key;
        key = `PR_KEY;
        return key[idx];
    endfunction : key_bit

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    seq_state_e state_q;      // sequencer state
    bit_idx_t   ptr_q;        // key pointer
    bit_idx_t   xcnt_q;       // transfer bit count
    logic       sel_low_q;    // select was low last clock
    logic       we_seen_q;    // write strobe seen in this cycle
    logic       din_q;        // data bit caught under the strobe
    byte_t      shift_q;      // assembling write byte
    logic       pend_q;       // finished byte waiting for buffer
    reg_idx_t   pend_idx_q;   // its register number
    byte_t      pend_data_q;  // its value
    logic       dout_q;       // read bit for the data pin
    logic       cyc_end;      // select just rose: cycle done
    logic       wr_done;      // finished cycle was a write
    logic       rd_done;      // finished cycle was a read
    logic       cur_din;      // data bit of finished write
    logic       abort_pin;    // reset pin honoured and low
    logic       pf;           // supply below threshold
    logic       buf_ready;    // buffer can take a byte
    logic       byte_done;    // write finished a register

    // ---------------------------------------------------------------
    // bus cycle decode
    // ---------------------------------------------------------------
    // a cycle is counted when select rises; other-location cycles
    // never lower select, so they never touch progress
    assign cyc_end   = sel_low_q && i_chip_sel_in_n;
    assign wr_done   = cyc_end && we_seen_q;
    assign rd_done   = cyc_end && !we_seen_q;
    assign cur_din   = din_q;
    assign pf        = i_below_threshold;
    assign abort_pin = !i_abort_pin_n
                       && !i_clock_image[`PR_RST_EN_BIT];
    assign byte_done = (state_q == SEQ_XFER) && wr_done && !pf
                       && !abort_pin
                       && (xcnt_q[2:0] == `PR_BYTE_LAST);

    // track select, write strobe and write data per cycle
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sel_low_q <= 1'b0;
            we_seen_q <= 1'b0;
            din_q     <= 1'b0;
        end else begin
            sel_low_q <= !i_chip_sel_in_n;
            if (i_chip_sel_in_n) begin
                we_seen_q <= 1'b0;              // deselect
            end else if (!i_we_n) begin
                we_seen_q <= 1'b1;              // write mode
                din_q     <= i_data_in;
            end
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    // pattern recognition and transfer, abort has priority
    // power fail outranks the reset pin; either one drops back to idle
    // with pointer and count cleared, so no half-done attempt or
    // transfer can resume where it stopped
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= SEQ_IDLE;
            ptr_q   <= `PR_IDX_FIRST;
            xcnt_q  <= `PR_IDX_FIRST;
        end else if (pf) begin
            state_q <= SEQ_IDLE;
            ptr_q   <= `PR_IDX_FIRST;
            xcnt_q  <= `PR_IDX_FIRST;
        end else if (abort_pin) begin
            state_q <= SEQ_IDLE;
            ptr_q   <= `PR_IDX_FIRST;
            xcnt_q  <= `PR_IDX_FIRST;
        end else begin
            unique case (state_q)
                // locked: only a read can start an attempt
                SEQ_IDLE, SEQ_FAIL: begin
                    if (rd_done) begin
                        state_q <= SEQ_MATCH;
                        ptr_q   <= `PR_IDX_FIRST;
                    end
                    // writes here are ignored
                end
                // comparing: one key bit per finished write
                SEQ_MATCH: begin
                    if (rd_done) begin
                        ptr_q <= `PR_IDX_FIRST;
                    end else if (wr_done) begin
                        if (cur_din != key_bit(ptr_q)) begin
                            state_q <= SEQ_FAIL;
                        end else if (ptr_q == `PR_IDX_LAST) begin
                            state_q <= SEQ_XFER;
                            xcnt_q  <= `PR_IDX_FIRST;
                            ptr_q   <= `PR_IDX_FIRST;
                        end else begin
                            ptr_q <= ptr_q + 6'h01;
                        end
                    end
                end
                // unlocked: every finished cycle moves one bit
                SEQ_XFER: begin
                    if (cyc_end) begin
                        if (xcnt_q == `PR_IDX_LAST) begin
                            state_q <= SEQ_IDLE;
                            xcnt_q  <= `PR_IDX_FIRST;
                        end else begin
                            xcnt_q <= xcnt_q + 6'h01;
                        end
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // transfer data path
    // ---------------------------------------------------------------
    // write bits assemble lsb first; only transfer writes count
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shift_q <= 8'h00;
        end else if ((state_q == SEQ_XFER) && wr_done) begin
            shift_q <= {cur_din, shift_q[7:1]};
        end
    end

    // finished byte waits here until the buffer takes it
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pend_q      <= 1'b0;
            pend_idx_q  <= 3'h0;
            pend_data_q <= 8'h00;
        end else if (byte_done) begin
            pend_q      <= 1'b1;
            pend_idx_q  <= xcnt_q[5:3];
            pend_data_q <= {cur_din, shift_q[7:1]};
        end else if (buf_ready) begin
            pend_q <= 1'b0;
        end
    end

    // read bit for current transfer position
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dout_q <= 1'b0;
        end else begin
            dout_q <= i_clock_image[xcnt_q];
        end
    end

    // ---------------------------------------------------------------
    // pins
    // ---------------------------------------------------------------
    // memory select: forced high on power fail or during transfer,
    // otherwise the input select passes straight to the memory
    assign o_memory_sel_out_n = pf
                                || (state_q == SEQ_XFER)
                                || i_chip_sel_in_n;
    // data out driven only for transfer reads with output enable
    assign o_data_out_oe = (state_q == SEQ_XFER) && !pf
                           && !i_chip_sel_in_n && i_we_n
                           && !i_oe_n;
    assign o_data_out    = dout_q;
    assign o_xfer_active = (state_q == SEQ_XFER);

    // two-entry buffer toward the timekeeping core
    phantom_rtc_buf #(
        .WIDTH (11),
        .DEPTH (`PR_BUF_DEPTH)
    ) u_buf (
        .i_sys_clk   (i_sys_clk),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (pend_q),
        .o_in_ready  (buf_ready),
        .i_in_data   ({pend_idx_q, pend_data_q}),
        .o_out_valid (o_tk_valid),
        .i_out_ready (i_tk_ready),
        .o_out_data  ({o_tk_index, o_tk_data})
    );

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    a_pf_deselect: assert property (pf |-> o_memory_sel_out_n)
        else $error("memory select low during power fail");
    a_xfer_deselect: assert property (
        (state_q == SEQ_XFER) |-> o_memory_sel_out_n)
        else $error("memory select low during transfer");
    a_pass_through: assert property (
        (!pf && state_q != SEQ_XFER)
        |-> (o_memory_sel_out_n == i_chip_sel_in_n))
        else $error("memory select not following input");
    a_dout_gate: assert property (
        o_data_out_oe |-> (state_q == SEQ_XFER && !i_oe_n))
        else $error("data out driven outside transfer read");
    a_dout_deselect: assert property (
        i_chip_sel_in_n |-> !o_data_out_oe)
        else $error("data out driven while deselected");

    // unlock sequence
    a_read_arms: assert property (
        (rd_done && !pf && !abort_pin && state_q != SEQ_XFER)
        |=> (state_q == SEQ_MATCH && ptr_q == `PR_IDX_FIRST))
        else $error("read did not rearm pointer");
    a_match_step: assert property (
        (state_q == SEQ_MATCH && wr_done && !pf && !abort_pin
         && cur_din == key_bit(ptr_q) && ptr_q != `PR_IDX_LAST)
        |=> (ptr_q == $past(ptr_q) + 6'h01))
        else $error("pointer did not advance on match");
    a_miss_hold: assert property (
        (state_q == SEQ_MATCH && wr_done && !pf && !abort_pin
         && cur_din != key_bit(ptr_q))
        |=> (state_q == SEQ_FAIL && $stable(ptr_q)))
        else $error("mismatch not frozen");
    a_fail_ignore: assert property (
        (state_q == SEQ_FAIL && wr_done && !pf && !abort_pin)
        |=> (state_q == SEQ_FAIL))
        else $error("write after mismatch not ignored");
    a_match_idle: assert property (
        (state_q == SEQ_MATCH && !cyc_end && !pf && !abort_pin)
        |=> (state_q == SEQ_MATCH && $stable(ptr_q)))
        else $error("pointer moved without a finished cycle");
    a_unlock_done: assert property (
        (state_q == SEQ_MATCH && wr_done && !pf && !abort_pin
         && cur_din == key_bit(ptr_q) && ptr_q == `PR_IDX_LAST)
        |=> (state_q == SEQ_XFER && xcnt_q == `PR_IDX_FIRST))
        else $error("unlock not granted after full key");

    // transfer sequence
    a_xfer_step: assert property (
        (state_q == SEQ_XFER && cyc_end && !pf && !abort_pin
         && xcnt_q != `PR_IDX_LAST)
        |=> (state_q == SEQ_XFER && xcnt_q == $past(xcnt_q) + 6'h01))
        else $error("transfer count did not step");
    a_xfer_idle: assert property (
        (state_q == SEQ_XFER && !cyc_end && !pf && !abort_pin)
        |=> (state_q == SEQ_XFER && $stable(xcnt_q)))
        else $error("transfer count moved without a cycle");
    a_xfer_relock: assert property (
        (state_q == SEQ_XFER && cyc_end && !pf && !abort_pin
         && xcnt_q == `PR_IDX_LAST) |=> (state_q == SEQ_IDLE))
        else $error("no relock after last transfer cycle");
    a_key_nostore: assert property (
        $rose(pend_q) |-> ($past(state_q) == SEQ_XFER))
        else $error("byte stored outside transfer");

    // aborts
    a_pf_abort: assert property (pf |=> (state_q == SEQ_IDLE))
        else $error("power fail did not abort");
    a_pin_abort: assert property (
        abort_pin |=> (state_q == SEQ_IDLE))
        else $error("reset pin did not abort");

endmodule : phantom_rtc_access_sequencer

/* phantom_rtc_tk_model.sv */
// timekeeping core model: holds the clock image, takes written bytes
// assumes one clock and the design's active-low asynchronous reset
`timescale 1ns/1ps

module phantom_rtc_tk_model
    import phantom_rtc_pkg::*;
#(
    parameter logic [63:0] INIT_IMAGE = 64'h1234_5668_9A0B_CDEF
) (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_stall,
    input  wire logic                 i_tk_valid,
    input  wire phantom_rtc_pkg::reg_idx_t i_tk_index,
    input  wire phantom_rtc_pkg::byte_t    i_tk_data,
    output logic                      o_tk_ready,
    output logic [63:0]               o_clock_image,
    output logic [3:0]                o_taken
);
    // ----------------------------------------
    // byte intake
    // ----------------------------------------
    logic [63:0] image_q;  // live clock registers
    logic [3:0]  taken_q;  // bytes accepted so far

    // a stall holds the buffer head where it is
    assign o_tk_ready    = !i_stall;
    assign o_clock_image = image_q;
    assign o_taken       = taken_q;

    // register n sits in bits 8n+7..8n, bit 0 first
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            image_q <= INIT_IMAGE;
            taken_q <= 4'h0;
        end else if (i_tk_valid && o_tk_ready) begin
            image_q[8*i_tk_index +: 8] <= i_tk_data;
            taken_q <= taken_q + 4'h1;
        end
    end
endmodule : phantom_rtc_tk_model

/* tb.sv */
// self-checking bench of the phantom clock access sequencer
// assumes the design and the timekeeping model compiled before it
`timescale 1ns/1ps

module tb;
    import phantom_rtc_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [63:0] INIT = 64'h1234_5668_9A0B_CDEF; // bit 36 low
    localparam logic [63:0] PATT = 64'hA5C3_0F96_1E5A_D27B; // bit 36 high
    logic i_sys_clk = 1'h0, i_arst_n = 1'h0, chip_sel_n = 1'h1;
    logic oe_n = 1'h1, we_n = 1'h1, data_in = 1'h0, pf = 1'h0;
    logic abort_n = 1'h1, stall = 1'h0, tk_ready, tk_valid, xfer;
    logic mem_sel_n, d_out, d_oe, rd_bit, rd_oe;
    logic [63:0] image;
    logic [3:0]  taken;
    reg_idx_t    tk_idx;
    byte_t       tk_data;
    int mismatches = 0, tests_run = 0;

    always #5 i_sys_clk = !i_sys_clk;

    phantom_rtc_access_sequencer dut (.i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n), .i_chip_sel_in_n(chip_sel_n), .i_oe_n(oe_n),
        .i_we_n(we_n), .i_data_in(data_in), .i_below_threshold(pf),
        .i_abort_pin_n(abort_n), .i_clock_image(image),
        .i_tk_ready(tk_ready), .o_memory_sel_out_n(mem_sel_n),
        .o_data_out(d_out), .o_data_out_oe(d_oe), .o_xfer_active(xfer),
        .o_tk_valid(tk_valid), .o_tk_index(tk_idx), .o_tk_data(tk_data));
    phantom_rtc_tk_model #(.INIT_IMAGE(INIT)) u_tk (.i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n), .i_stall(stall), .i_tk_valid(tk_valid),
        .i_tk_index(tk_idx), .i_tk_data(tk_data), .o_tk_ready(tk_ready),
        .o_clock_image(image), .o_taken(taken));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                         input string what);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : check

    // key bytes c5 3a a3 5c twice, each lsb first
    function automatic logic key_bit(input int i);
        logic [7:0] kb;
        case ((i / 8) % 4)
            0: kb = 8'hC5;
            1: kb = 8'h3A;
            2: kb = 8'hA3;
            default: kb = 8'h5C;
        endcase
        return kb[i % 8];
    endfunction : key_bit

    // one select-framed cycle, memory select judged mid-cycle
    task automatic bus(input logic wr, input logic din, input logic exp_sel);
        @(negedge i_sys_clk);
        chip_sel_n = 1'h0;
        we_n = !wr;
        oe_n = wr;
        data_in = din;
        repeat (3) @(negedge i_sys_clk);
        check(mem_sel_n, exp_sel, "memory select");
        rd_bit = d_out;
        rd_oe = d_oe;
        chip_sel_n = 1'h1;
        we_n = 1'h1;
        oe_n = 1'h1;
    endtask : bus

    // arm, send the key (one bit flipped at bad), optional foreign cycles
    task automatic unlock(input int n, input int bad, input logic inter);
        bus(1'h0, 1'h0, 1'h0);
        for (int i = 0; i < n; i++) begin
            bus(1'h1, key_bit(i) ^ (i == bad), 1'h0);
            if (inter) begin
                @(negedge i_sys_clk);
                we_n = 1'h0;
                oe_n = 1'h0;
                @(negedge i_sys_clk);
                we_n = 1'h1;
                oe_n = 1'h1;
            end
        end
        repeat (2) @(negedge i_sys_clk);
        check(xfer, n == 64 && bad < 0, "unlocked");
    endtask : unlock

    // n transfer reads from start, checked against the expected image
    task automatic reads(input int start, input int n, input logic [63:0] e);
        for (int i = start; i < start + n; i++) begin
            bus(1'h0, 1'h0, 1'h1);
            check(rd_oe, 1'h1, "data out enable");
            check(rd_bit, e[i], "read bit");
        end
    endtask : reads

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_pass_pf();
        bus(1'h0, 1'h0, 1'h0);
        pf = 1'h1;
        bus(1'h0, 1'h0, 1'h1);
        pf = 1'h0;
        bus(1'h1, 1'h1, 1'h0);
        $display("test pass_pf done");
    endtask : t_pass_pf

    task automatic t_key_faults();
        unlock(64, 10, 1'h0);
        unlock(30, -1, 1'h0);
        unlock(64, -1, 1'h0);
        check(taken, 4'h0, "key writes stored");
        reads(0, 64, INIT);
        repeat (2) @(negedge i_sys_clk);
        check(xfer, 1'h0, "relock");
        $display("test key_faults done");
    endtask : t_key_faults

    task automatic t_aborts();
        unlock(64, -1, 1'h1);
        reads(0, 5, INIT);
        abort_n = 1'h0;
        repeat (2) @(negedge i_sys_clk);
        abort_n = 1'h1;
        check(xfer, 1'h0, "abort pin");
        unlock(64, -1, 1'h0);
        reads(0, 5, INIT);
        pf = 1'h1;
        bus(1'h0, 1'h0, 1'h1);
        check(xfer, 1'h0, "power fail abort");
        pf = 1'h0;
        bus(1'h0, 1'h0, 1'h0);
        check(image, INIT, "image kept");
        $display("test aborts done");
    endtask : t_aborts

    task automatic t_write_xfer();
        int k;
        unlock(64, -1, 1'h0);
        stall = 1'h1;
        for (int i = 0; i < 64; i++) begin
            bus(1'h1, PATT[i], 1'h1);
            check(rd_oe, 1'h0, "data out on write");
            if (i == 20) begin
                check(taken, 4'h0, "stalled intake");
                check(tk_valid, 1'h1, "head waiting");
                stall = 1'h0;
            end
        end
        k = 0;
        while (taken != 4'h8 && k < 100) begin
            @(negedge i_sys_clk);
            k++;
        end
        if (k == 100) begin
            mismatches++;
            conclude();
        end
        check(image, PATT, "written image");
        check(xfer, 1'h0, "relock after write");
        $display("test write_xfer done");
    endtask : t_write_xfer

    task automatic t_abort_ignored();
        unlock(64, -1, 1'h0);
        abort_n = 1'h0;
        repeat (2) @(negedge i_sys_clk);
        abort_n = 1'h1;
        check(xfer, 1'h1, "abort ignored");
        // first transfer cycle: a read with output enable high
        @(negedge i_sys_clk);
        chip_sel_n = 1'h0;
        repeat (3) @(negedge i_sys_clk);
        check(d_oe, 1'h0, "read without enable");
        chip_sel_n = 1'h1;
        reads(1, 63, PATT);
        $display("test abort_ignored done");
    endtask : t_abort_ignored

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(negedge i_sys_clk);
        i_arst_n = 1'h1;
        t_pass_pf();
        t_key_faults();
        t_aborts();
        t_write_xfer();
        t_abort_ignored();
        conclude();
    end
endmodule : tb
